/* asp_pkg.sv */
// How it works
// - 8-bit frame: start, 8 data LSB-first, stop
// - 9-bit frame adds ninth bit before stop
// - Frame mode bit picks 8 or 9 bits
// - Ninth transmit bit sent in 9-bit mode
// - 8-bit accept stores stop in ninth bit
// - 9-bit accept stores ninth bit, ignores stop
// - Data buffer write starts transmission at next bit tick
// - Transmit flag set at stop bit start
// - No reception until receive enable set
// - 8-bit accept: flag clear, stop checked if enabled
// - 9-bit multiproc accept needs ninth bit one
// - Accept loads latch, ninth bit, sets flag
// - Overrun keeps old byte, drops new one
// - Receiver captures next byte before read
// - Writes go to transmit, reads return receive
// - Flags cleared only by software writes
// - Interrupt request when either flag set
// - Transmit timing from timer low byte reload
// - Hidden receive timer copy shares reload value
// - Both timer overflows divided by two
// - Start edge forces receive timer reload
// - Overflow rate is clock over 256 minus reload
// - Timer clock source selectable six ways
// - Control register layout, reset 01000000
// - Receive enable zero disables receiver
package asp_pkg;
    // Register addresses
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_DATA   = 4'h1;
    localparam logic [3:0] ADDR_TIMER  = 4'h2;
    localparam logic [3:0] ADDR_RELOAD = 4'h3;
    localparam logic [3:0] ADDR_TCFG   = 4'h4;
    // Control register fields
    localparam int BIT_MODE = 7;
    localparam int BIT_ONE  = 6;
    localparam int BIT_MCE  = 5;
    localparam int BIT_REN  = 4;
    localparam int BIT_TB8  = 3;
    localparam int BIT_RB8  = 2;
    localparam int BIT_TI   = 1;
    localparam int BIT_RI   = 0;
    localparam logic [7:0] CTRL_RESET = 8'h40;
    // Timer config fields
    localparam int BIT_TRUN = 3;
    localparam int SRC_LSB  = 0;
    // Clock source codes
    localparam logic [2:0] SRC_SYS    = 3'h0;
    localparam logic [2:0] SRC_DIV4   = 3'h1;
    localparam logic [2:0] SRC_DIV12  = 3'h2;
    localparam logic [2:0] SRC_DIV48  = 3'h3;
    localparam logic [2:0] SRC_EXT8   = 3'h4;
    localparam logic [2:0] SRC_EXTIN  = 3'h5;
    // Prescaler terminal counts
    localparam logic [5:0] DIV4_LAST  = 6'h03;
    localparam logic [5:0] DIV12_LAST = 6'h0B;
    localparam logic [5:0] DIV48_LAST = 6'h2F;
    localparam logic [2:0] EXT8_LAST  = 3'h7;
    // Frame lengths in data bits
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    // Half bit ticks per bit
    localparam logic [1:0] HALF_LAST = 2'h1;
    typedef enum logic [1:0] {ASP_IDLE, ASP_START, ASP_DATA, ASP_STOP} asp_state_e;
endpackage

/* asp_uart.sv */
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module asp_uart
    import asp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       ext_osc_tick,
    input  wire logic       timer_ext_input,
    input  wire logic       serial_in_pin,
    output logic            serial_out_pin,
    output logic            irq_q
);
    // Block overview
    // Register map: control, data, timer, reload, timer config
    // Control write replaces all bits but the constant one
    // Data write loads the transmitter, data read gives receive latch
    // Transmit data is never visible to reads
    // Timer config: run bit above a three-bit source code
    // Source codes: system clock, divide by 4, 12, 48
    // Further codes: external oscillator over 8, external pin edges
    // Unused source codes give no ticks
    // Transmit timer counts ticks, reloads on overflow
    // Receive timer shares reload, restarts at each start edge
    // Two overflows make one bit time on either side
    // Bit time is two times 256 minus reload ticks
    // Transmit bit ticks follow the free-running timer phase
    // So the start bit may begin up to one bit time late
    // Receive samples fall one overflow after each bit edge
    // That is the middle of every bit
    // Frame: start low, data LSB first, optional ninth bit, stop high
    // Frame mode bit picks eight or nine data bits
    // Transmit flag rises as the stop bit begins
    // Receive flag rises at the stop bit sample
    // Acceptance needs receive flag clear
    // Multiprocessor bit adds a stop or ninth bit check
    // A refused frame leaves latch and ninth bit alone
    // Flags stay set until software writes control
    // Interrupt output mirrors the two flags one cycle late
    // Read data stand one cycle, zero otherwise
    // No wait states on the register port
    // Pins are taken as synchronous to the clock
    // Receive pin is watched through one history flop
    // Register state
    logic [7:0] ctrl_q;            // Control register bits
    logic [7:0] rx_latch_q;        // Buffered receive byte
    logic [7:0] baud_timer_low_byte_q; // Transmit timer
    logic [7:0] baud_reload_value_q;   // Shared reload
    logic [3:0] tcfg_q;            // Run bit and source
    logic [7:0] rx_timer_q;        // Hidden receive timer
    logic [5:0] pre_q;             // System prescaler
    logic [2:0] ext_q;             // External /8 count
    logic       ext_in_q;          // External input last level
    logic       tick;              // Timer input tick
    logic       tx_ovf;            // Transmit timer overflow
    logic       rx_ovf;            // Receive timer overflow
    logic       tx_half_q;         // Transmit divide by two
    logic       rx_half_q;         // Receive divide by two
    logic       tx_bit;            // Transmit bit enable
    logic       rx_bit;            // Receive centre enable
    // Transmit side
    asp_state_e tx_st_q;
    logic [8:0] tx_sh_q;           // Data plus ninth bit
    logic [3:0] tx_cnt_q;
    logic       tx_set;            // Transmit flag set pulse
    // Receive side
    asp_state_e rx_st_q;
    logic [8:0] rx_sh_q;
    logic [3:0] rx_cnt_q;
    logic       rx_in_q;           // Last pin level
    logic       rx_start;          // Falling edge seen idle
    logic       rx_accept;         // Frame accepted
    logic       rx_done;           // Stop sample moment
    logic       ninth_rx_d;        // Value for ninth rx bit

    // Frame data bit count per mode
    function automatic logic [3:0] frame_bits(input logic mode);
        return mode ? BITS_9 : BITS_8;
    endfunction

    // Register write strobes
    wire wr_ctrl = wr && (addr == ADDR_CTRL);
    wire wr_data = wr && (addr == ADDR_DATA);

    // Shared prescaler, one count per clock
    // Wraps at the divide by 48 terminal count
    // Divide by 4 and 12 taps decode phases of the same count
    // Hazard: no reset of this count on source change
    // First tick after a switch may come early
    // Timer clock prescaler for system sources
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pre_q <= 6'h00;
        end else if (pre_q == DIV48_LAST) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= pre_q + 6'h01;
        end
    end

    // External oscillator pulses counted modulo eight
    // Pin level kept for rising edge detection
    // External oscillator divide by eight and edge capture
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ext_q    <= 3'h0;
            ext_in_q <= 1'b0;
        end else begin
            ext_in_q <= timer_ext_input;
            if (ext_osc_tick) begin
                ext_q <= ext_q + 3'h1;
            end
        end
    end

    // One tick a cycle at most, gated by the run bit
    // Timer input tick source select
    always_comb begin
        unique case (tcfg_q[SRC_LSB +: 3])
            SRC_SYS:   tick = 1'b1;
            SRC_DIV4:  tick = (pre_q[1:0] == DIV4_LAST[1:0]);
            SRC_DIV12: tick = (pre_q == DIV12_LAST) || (pre_q == DIV12_LAST + 6'h0C)
                              || (pre_q == DIV12_LAST + 6'h18) || (pre_q == DIV48_LAST);
            SRC_DIV48: tick = (pre_q == DIV48_LAST);
            SRC_EXT8:  tick = ext_osc_tick && (ext_q == EXT8_LAST);
            SRC_EXTIN: tick = timer_ext_input && !ext_in_q;
            default:   tick = 1'b0;
        endcase
        tick = tick && tcfg_q[BIT_TRUN];
    end

    // Overflow when timer wraps past FF
    assign tx_ovf = tick && (baud_timer_low_byte_q == 8'hFF);
    assign rx_ovf = tick && (rx_timer_q == 8'hFF);
    assign tx_bit = tx_ovf && tx_half_q;
    assign rx_bit = rx_ovf && rx_half_q && !rx_start;
    assign rx_start = (rx_st_q == ASP_IDLE) && ctrl_q[BIT_REN] && rx_in_q && !serial_in_pin;

    // Software may load the count directly
    // Writes win over ticks in the same cycle
    // Overflow reload takes the shared reload value
    // Transmit timer, auto reload, period 256 minus reload
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            baud_timer_low_byte_q <= 8'h00;
        end else if (wr && addr == ADDR_TIMER) begin
            baud_timer_low_byte_q <= wdata;
        end else if (tx_ovf) begin
            baud_timer_low_byte_q <= baud_reload_value_q;
        end else if (tick) begin
            baud_timer_low_byte_q <= baud_timer_low_byte_q + 8'h01;
        end
    end

    // Receive timer runs from the same ticks as transmit
    // Reload at a start edge puts its overflow mid-bit
    // Divide-by-two phase set so the first overflow samples
    // Hidden receive timer copy
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_timer_q <= 8'h00;
            rx_half_q  <= 1'b0;
        end else if (rx_start) begin
            rx_timer_q <= baud_reload_value_q;
            rx_half_q  <= 1'b1;                // First overflow at bit centre
        end else if (rx_ovf) begin
            rx_timer_q <= baud_reload_value_q;
            rx_half_q  <= !rx_half_q;
        end else if (tick) begin
            rx_timer_q <= rx_timer_q + 8'h01;
        end
    end

    // Transmit divide by two
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_half_q <= 1'b0;
        end else if (tx_ovf) begin
            tx_half_q <= !tx_half_q;
        end
    end

    // Reload and timer config registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            baud_reload_value_q <= 8'h00;
            tcfg_q              <= 4'h0;
        end else begin
            if (wr && addr == ADDR_RELOAD) begin
                baud_reload_value_q <= wdata;
            end
            if (wr && addr == ADDR_TCFG) begin
                tcfg_q <= wdata[3:0];
            end
        end
    end

    // Transmit sequence per bit tick
    // Idle: line held high
    // Start: drive the start bit low
    // Data: shift out one bit per tick, LSB first
    // Data done: drive stop level, raise transmit flag
    // Stop: one more tick, then back to idle
    // A data write mid-frame restarts with the new byte
    // The line goes high at once on such a restart
    // Ninth bit is taken from control at the write
    // Transmit state machine
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_st_q        <= ASP_IDLE;
            tx_sh_q        <= 9'h1FF;
            tx_cnt_q       <= 4'h0;
            serial_out_pin <= 1'b1;
        end else if (wr_data) begin
            tx_sh_q        <= {ctrl_q[BIT_TB8], wdata};
            tx_cnt_q       <= 4'h0;
            tx_st_q        <= ASP_START;
            serial_out_pin <= 1'b1;
        end else if (tx_bit) begin
            unique case (tx_st_q)
                ASP_IDLE: serial_out_pin <= 1'b1;
                ASP_START: begin
                    serial_out_pin <= 1'b0; // Start bit
                    tx_st_q        <= ASP_DATA;
                end
                ASP_DATA: begin
                    if (tx_cnt_q == frame_bits(ctrl_q[BIT_MODE])) begin
                        serial_out_pin <= 1'b1;
                        tx_st_q        <= ASP_STOP;
                    end else begin
                        serial_out_pin <= tx_sh_q[0]; // LSB first
                        tx_sh_q        <= {1'b1, tx_sh_q[8:1]};
                        tx_cnt_q       <= tx_cnt_q + 4'h1;
                    end
                end
                ASP_STOP: tx_st_q <= ASP_IDLE; // Stop bit time over
            endcase
        end
    end
    assign tx_set = tx_bit && (tx_st_q == ASP_DATA) && !wr_data
                    && (tx_cnt_q == frame_bits(ctrl_q[BIT_MODE]));

    // Receiver pin history
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_in_q <= 1'b1;
        end else begin
            rx_in_q <= serial_in_pin;
        end
    end

    // Receive sequence per centre tick
    // Idle: wait for a high to low step on the pin
    // Start edge also restarts the receive timer
    // Start: pin still low at centre, else a glitch
    // Data: shift in eight or nine bits, LSB first
    // Stop: decide acceptance, then back to idle
    // Idle right after stop lets a new frame start at once
    // Clearing receive enable drops any frame in flight
    // Mode changes mid-frame give a mixed frame length
    // Receive state machine, samples on centre ticks
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_st_q  <= ASP_IDLE;
            rx_sh_q  <= 9'h000;
            rx_cnt_q <= 4'h0;
        end else if (!ctrl_q[BIT_REN]) begin
            rx_st_q <= ASP_IDLE;
        end else if (rx_start) begin
            rx_st_q  <= ASP_START;
            rx_cnt_q <= 4'h0;
        end else if (rx_bit) begin
            unique case (rx_st_q)
                ASP_IDLE: rx_st_q <= ASP_IDLE;
                ASP_START: begin
                    // False start rejected at centre
                    rx_st_q <= serial_in_pin ? ASP_IDLE : ASP_DATA;
                end
                ASP_DATA: begin
                    rx_sh_q  <= {serial_in_pin, rx_sh_q[8:1]}; // LSB first
                    rx_cnt_q <= rx_cnt_q + 4'h1;
                    if (rx_cnt_q + 4'h1 == frame_bits(ctrl_q[BIT_MODE])) begin
                        rx_st_q <= ASP_STOP;
                    end
                end
                ASP_STOP: rx_st_q <= ASP_IDLE;
            endcase
        end
    end

    // Eight-bit mode: stop level goes to the ninth receive bit
    // Nine-bit mode: ninth data bit kept, stop level ignored
    // Multiprocessor bit filters on that same bit
    // A full latch refuses the frame, old byte kept
    // Receive flag set even if software clears it that cycle
    // Acceptance decision at stop sample
    assign rx_done = rx_bit && (rx_st_q == ASP_STOP) && ctrl_q[BIT_REN];
    always_comb begin
        if (ctrl_q[BIT_MODE]) begin
            ninth_rx_d = rx_sh_q[8];
            rx_accept  = !ctrl_q[BIT_RI] && (!ctrl_q[BIT_MCE] || rx_sh_q[8]);
        end else begin
            ninth_rx_d = serial_in_pin;
            rx_accept  = !ctrl_q[BIT_RI] && (!ctrl_q[BIT_MCE] || serial_in_pin);
        end
        rx_accept = rx_accept && rx_done;
    end

    // Receive latch, overrun keeps the older byte
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_latch_q <= 8'h00;
        end else if (rx_accept) begin
            // 8-bit frame sits in upper bits of the 9-bit shifter
            rx_latch_q <= ctrl_q[BIT_MODE] ? rx_sh_q[7:0] : rx_sh_q[8:1];
        end
    end

    // Bit six always reads one
    // Software may set the flags itself by writing ones
    // Hardware sets come after the write, so they win
    // Control register; hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {wdata[7], 1'b1, wdata[5:0]};
            end
            if (rx_accept) begin
                ctrl_q[BIT_RB8] <= ninth_rx_d;
                ctrl_q[BIT_RI]  <= 1'b1;
            end
            if (tx_set) begin
                ctrl_q[BIT_TI] <= 1'b1;
            end
        end
    end

    // Interrupt request level
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ctrl_q[BIT_TI] || ctrl_q[BIT_RI];
        end
    end

    // Read port has no side effects
    // Reading data leaves the receive flag set
    // Timer count readable for software checks
    // Unmapped reads return zero
    // Read data one cycle after read strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                ADDR_CTRL:   rdata <= ctrl_q;
                ADDR_DATA:   rdata <= rx_latch_q;
                ADDR_TIMER:  rdata <= baud_timer_low_byte_q;
                ADDR_RELOAD: rdata <= baud_reload_value_q;
                ADDR_TCFG:   rdata <= {4'h0, tcfg_q};
                default:     rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // asp_uart

/* asp_checker.sv */
`timescale 1ns/1ps
module asp_checker
    import asp_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       serial_out_pin,
    input wire logic       irq_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic ctrl_wr_q; // Ctrl written in the last cycle
    // Remember a control write so flag hold can be judged
    always_ff @(posedge clk) begin
        if (!rst_b)
            ctrl_wr_q <= 1'b0;
        else
            ctrl_wr_q <= wr && addr == ADDR_CTRL;
    end
    // Write then read of one address, no gap
    sequence s_wr_rd(logic [3:0] a);
        wr && addr == a ##1 rd && addr == a;
    endsequence
    AST_RESET_OUT: assert property ($rose(rst_b) |-> serial_out_pin && rdata == 8'h00 && !irq_q)
        else $error("outputs not idle after reset");
    AST_RDATA_IDLE: assert property (!rd |=> rdata == 8'h00)
        else $error("read data without read");
    AST_UNMAPPED: assert property (rd && addr > ADDR_TCFG |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_ONE: assert property (rd && addr == ADDR_CTRL |=> rdata[BIT_ONE])
        else $error("unused control bit not one");
    AST_CTRL_RW: assert property (s_wr_rd(ADDR_CTRL) |=> (rdata & 8'hF8) == (($past(wdata, 2) & 8'hB8) | 8'h40))
        else $error("control bits not written");
    AST_RELOAD_RW: assert property (s_wr_rd(ADDR_RELOAD) |=> rdata == $past(wdata, 2))
        else $error("reload value not written");
    AST_IRQ_MATCH: assert property (rd && addr == ADDR_CTRL |=> irq_q == (rdata[BIT_TI] || rdata[BIT_RI]))
        else $error("interrupt does not follow flags");
    AST_IRQ_HOLD: assert property (irq_q && !ctrl_wr_q |=> irq_q)
        else $error("flag dropped without software write");
endmodule // asp_checker

bind asp_uart asp_checker asp_checker_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .serial_out_pin(serial_out_pin), .irq_q(irq_q));

/* asp_remote.sv */
`timescale 1ns/1ps
module asp_remote #(
    parameter int BIT = 8
) (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    int          rx_len = 10; // Bits heard per frame, start included
    int          rx_cnt = 0;  // Frames heard so far
    logic [10:0] rx_frame;    // Last frame heard, start at bit 0
    initial line_out = 1'b1;
    // Send a frame LSB first, then idle high
    task automatic send(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            line_out <= f[i];
            repeat (BIT - 1) @(posedge clk);
        end
        @(posedge clk);
        line_out <= 1'b1;
    endtask
    // Listen: sample each bit at its centre
    always begin
        @(negedge line_in);
        repeat (BIT / 2) @(negedge clk);
        for (int i = 0; i < rx_len; i++) begin
            rx_frame[i] = line_in;
            repeat (BIT) @(negedge clk);
        end
        rx_cnt++;
    end
endmodule // asp_remote

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import asp_pkg::*;
;
    localparam int         BIT    = 8; // Cycles per bit with reload FC
    localparam logic [7:0] C_REN  = 8'h01 << BIT_REN;
    localparam logic [7:0] C_MCE  = 8'h01 << BIT_MCE;
    localparam logic [7:0] C_MODE = 8'h01 << BIT_MODE;
    localparam logic [7:0] C_TB8  = 8'h01 << BIT_TB8;
    logic       clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       ext_osc_tick = 1'b0, timer_ext_input = 1'b0;
    logic       serial_in_pin, serial_out_pin, irq_q;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, q;
    int         n_fail = 0, n_checks = 0;
    always #5 clk = ~clk;
    // External timer sources keep ticking
    always @(posedge clk) begin
        ext_osc_tick <= ~ext_osc_tick;
        timer_ext_input <= ~timer_ext_input;
    end
    asp_uart asp_uart_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ext_osc_tick(ext_osc_tick), .timer_ext_input(timer_ext_input), .serial_in_pin(serial_in_pin),
        .serial_out_pin(serial_out_pin), .irq_q(irq_q));
    asp_remote #(.BIT(BIT)) asp_remote_i (.clk(clk), .line_in(serial_out_pin), .line_out(serial_in_pin));
    // Compare and count
    task automatic chk(input string s, input logic [10:0] e, input logic [10:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    // One write cycle
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Write, then read the same place with no gap
    task automatic wrrd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] g);
        wreg(a, d);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        g = rdata;
    endtask
    // One read cycle, data taken in the next cycle
    task automatic rreg(input logic [3:0] a, output logic [7:0] g);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        g = rdata;
    endtask
    task automatic t_reset;
        rreg(ADDR_CTRL, q);
        chk("ctrl reset", CTRL_RESET, q);
        rreg(4'hF, q);
        chk("unmapped read", 8'h00, q);
        $display("test reset done");
    endtask
    // Every clock source, then stopped; counts after 96 cycles
    task automatic t_timer;
        int e[7] = '{98, 24, 8, 2, 6, 49, 0};
        for (int i = 0; i < 7; i++) begin
            wreg(ADDR_TCFG, 8'h00);
            wreg(ADDR_RELOAD, 8'h00);
            wreg(ADDR_TIMER, 8'h00);
            wreg(ADDR_TCFG, {4'h0, i < 6, i < 6 ? i[2:0] : SRC_SYS});
            repeat (96) @(posedge clk);
            rreg(ADDR_TIMER, q);
            chk("timer count", 11'h001, {10'h000, q + 3 >= e[i] && q <= e[i] + 3});
        end
        wreg(ADDR_TCFG, 8'h08 | SRC_SYS);
        wrrd(ADDR_RELOAD, 8'hFC, q);
        chk("reload", 8'hFC, q);
        $display("test timer done");
    endtask
    // Send one byte out and judge the frame and flags
    task automatic t_tx(input logic [7:0] c, input logic [7:0] d);
        int          n;
        logic [10:0] f;
        logic [10:0] m;
        n = asp_remote_i.rx_cnt;
        asp_remote_i.rx_len = c[BIT_MODE] ? 11 : 10;
        m = c[BIT_MODE] ? 11'h7FF : 11'h3FF;
        f = c[BIT_MODE] ? {1'b1, c[BIT_TB8], d, 1'b0} : {2'b01, d, 1'b0};
        wrrd(ADDR_CTRL, c, q);
        chk("ctrl write", c | CTRL_RESET, q);
        wreg(ADDR_DATA, d);
        rreg(ADDR_CTRL, q);
        chk("tx flag early", 8'h00, q & 8'h02);
        for (int i = 0; i < 4000 && asp_remote_i.rx_cnt == n; i++) @(posedge clk);
        chk("tx frame", f & m, asp_remote_i.rx_frame & m);
        rreg(ADDR_CTRL, q);
        chk("tx flag", 8'h02, q & 8'h03);
        chk("irq set", 11'h001, irq_q);
        wreg(ADDR_CTRL, c);
        @(posedge clk);
        @(negedge clk);
        chk("irq clear", 11'h000, irq_q);
        $display("test tx done");
    endtask
    // Receive one frame and judge acceptance
    task automatic t_rx(input logic [7:0] c, input logic [10:0] f, input logic acc);
        wreg(ADDR_CTRL, c);
        asp_remote_i.send(f, c[BIT_MODE] ? 11 : 10);
        repeat (BIT) @(posedge clk);
        rreg(ADDR_CTRL, q);
        chk("rx flag", acc, q[BIT_RI]);
        if (acc) begin
            chk("ninth rx", f[9], q[BIT_RB8]);
            rreg(ADDR_DATA, q);
            chk("rx data", f[8:1], q);
        end
        $display("test rx done");
    endtask
    // Back-to-back frames, read in flight, then an overrun
    task automatic t_buf;
        wreg(ADDR_CTRL, C_REN);
        asp_remote_i.send({2'b01, 8'h11, 1'b0}, 10);
        fork
            asp_remote_i.send({2'b01, 8'h22, 1'b0}, 10);
            begin
                repeat (3 * BIT) @(posedge clk);
                rreg(ADDR_DATA, q);
                chk("first byte", 8'h11, q);
                wreg(ADDR_CTRL, C_REN);
            end
        join
        repeat (BIT) @(posedge clk);
        rreg(ADDR_DATA, q);
        chk("second byte", 8'h22, q);
        asp_remote_i.send({2'b01, 8'h33, 1'b0}, 10);
        repeat (BIT) @(posedge clk);
        rreg(ADDR_DATA, q);
        chk("overrun byte", 8'h22, q);
        $display("test buffer done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        #400000;
        n_fail++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_timer();
        t_tx(8'h00, 8'hA5);
        t_tx(C_MODE | C_TB8, 8'h3C);
        t_tx(C_MODE, 8'hC3);
        t_rx(C_REN, {2'b00, 8'h96, 1'b0}, 1'b1);
        t_rx(C_REN | C_MCE, {2'b00, 8'h5A, 1'b0}, 1'b0);
        t_rx(C_REN | C_MCE, {2'b01, 8'h5A, 1'b0}, 1'b1);
        t_rx(C_MODE | C_REN | C_MCE, {2'b10, 8'hC3, 1'b0}, 1'b0);
        t_rx(C_MODE | C_REN, {2'b00, 8'h3C, 1'b0}, 1'b1);
        t_rx(C_MODE | C_REN | C_MCE, {2'b11, 8'hE7, 1'b0}, 1'b1);
        t_rx(8'h00, {2'b01, 8'h81, 1'b0}, 1'b0);
        t_buf();
        end_of_test();
    end
endmodule // tb_top
